/* File: design/bgp_map.vh */
`ifndef BGP_MAP_VH
`define BGP_MAP_VH

// register byte offsets
`define BGP_ID_OFS       12'h000
`define BGP_BANKEN_OFS   12'h008
`define BGP_PAIR01_BASE  12'h010
`define BGP_PAIR2_BASE   12'h038
`define BGP_PAIR_SPAN    12'h028
// offsets inside one pair block
`define BGP_DIR_OFS      12'h000
`define BGP_OUT_OFS      12'h004
`define BGP_SET_OFS      12'h008
`define BGP_CLR_OFS      12'h00c
`define BGP_IN_OFS       12'h010
`define BGP_SETRIS_OFS   12'h014
`define BGP_CLRRIS_OFS   12'h018
`define BGP_SETFAL_OFS   12'h01c
`define BGP_CLRFAL_OFS   12'h020
`define BGP_STAT_OFS     12'h024

// line layout
`define BGP_LINES        48
`define BGP_BANK_W       16
`define BGP_BANKS        3
`define BGP_POP_MASK     48'h07f3_07ff_3dff
`define BGP_INT_MASK     48'h07f3_07ff_3dff
`define BGP_PAIR01_LANES 48'h0000_ffff_ffff
`define BGP_PAIR2_LANES  48'hffff_0000_0000

// reset values
`define BGP_DIR_RST      48'hffff_ffff_ffff
`define BGP_OUT_RST      48'h0000_0000_0000
`define BGP_BANKEN_RST   3'h0
`define BGP_ID_VALUE     32'h0000_5a01  // arbitrary id value

// clocking
`define BGP_PLL_DIV      6
`define BGP_CLK_MHZ      40
`define BGP_MAX_MHZ      10
`define BGP_TICK_CYC     ((`BGP_CLK_MHZ + `BGP_MAX_MHZ - 1) / `BGP_MAX_MHZ)

`endif

/* File: design/bgp_sync_edge.v */
`timescale 1ns/1ps
`default_nettype none
module bgp_sync_edge
#(
  parameter W = 48
)
(
  input  wire         ref_clk,
  input  wire         srst,
  input  wire [W-1:0] pinIn,
  input  wire         tick,
  output reg  [W-1:0] level,
  output reg  [W-1:0] rise,
  output reg  [W-1:0] fall
);

reg [W-1:0] meta;
reg [W-1:0] sync;
reg         primed;

// first stage feeds only the second
always @(posedge ref_clk)
begin
  meta <= pinIn;
  sync <= meta;
end

// edges judged on the slow tick so the port never runs past its rate
always @(posedge ref_clk)
begin
  if (srst)
  begin
    level <= {W{1'b0}};
    rise  <= {W{1'b0}};
    fall  <= {W{1'b0}};
    primed <= 1'b0;
  end
  else if (tick)
  begin
    level <= sync;
    // first tick after reset only loads the level: no false edge
    rise  <= primed ? (sync & ~level) : {W{1'b0}};
    fall  <= primed ? (~sync & level) : {W{1'b0}};
    primed <= 1'b1;
  end
  else
  begin
    rise <= {W{1'b0}};
    fall <= {W{1'b0}};
  end
end

endmodule
`default_nettype wire

/* File: design/bgp_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "bgp_map.vh"
module bgp_port
#(
  parameter [47:0] POP_MASK = `BGP_POP_MASK,
  parameter [47:0] INT_MASK = `BGP_INT_MASK,
  parameter [31:0] ID_VALUE = `BGP_ID_VALUE
)
(
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [47:0] ioLineIn,
  output reg  [47:0] ioLineOut,
  output reg  [47:0] ioLineOe,
  output reg  [47:0] lineEvent,
  output reg  [2:0]  bankEvent,
  output reg  [2:0]  dmaEvent
);

localparam integer TICK_LAST = `BGP_TICK_CYC - 1;
localparam [2:0]   TICK_MAX  = TICK_LAST[2:0];

////////////////////////////////////////////////////////////////////////////////
// state

reg  [47:0] dirIn;
reg  [47:0] outLvl;
reg  [47:0] risEn;
reg  [47:0] falEn;
reg  [47:0] intStat;
reg  [2:0]  bankEn;
reg  [2:0]  tickCnt;
reg         tick;

reg  [47:0] next_dirIn;
reg  [47:0] next_outLvl;
reg  [47:0] next_risEn;
reg  [47:0] next_falEn;
reg  [47:0] next_intStat;
reg  [2:0]  next_bankEn;

wire [47:0] inLvl;
wire [47:0] riseEv;
wire [47:0] fallEv;

////////////////////////////////////////////////////////////////////////////////
// rate tick: clock is the pll/6 peripheral clock, held under the ceiling

always @(posedge ref_clk)
begin
  if (srst)
  begin
    tickCnt <= 3'h0;
    tick    <= 1'b0;
  end
  else if (tickCnt == TICK_MAX)
  begin
    tickCnt <= 3'h0;
    tick    <= 1'b1;
  end
  else
  begin
    tickCnt <= tickCnt + 3'h1;
    tick    <= 1'b0;
  end
end

// one edge block per bank, all sharing the rate tick
bgp_sync_edge #(
  .W (`BGP_BANK_W)
) uSync0 (
  .ref_clk (ref_clk),
  .srst    (srst),
  .pinIn   (ioLineIn[15:0]),
  .tick    (tick),
  .level   (inLvl[15:0]),
  .rise    (riseEv[15:0]),
  .fall    (fallEv[15:0])
);

bgp_sync_edge #(
  .W (`BGP_BANK_W)
) uSync1 (
  .ref_clk (ref_clk),
  .srst    (srst),
  .pinIn   (ioLineIn[31:16]),
  .tick    (tick),
  .level   (inLvl[31:16]),
  .rise    (riseEv[31:16]),
  .fall    (fallEv[31:16])
);

bgp_sync_edge #(
  .W (`BGP_BANK_W)
) uSync2 (
  .ref_clk (ref_clk),
  .srst    (srst),
  .pinIn   (ioLineIn[47:32]),
  .tick    (tick),
  .level   (inLvl[47:32]),
  .rise    (riseEv[47:32]),
  .fall    (fallEv[47:32])
);

////////////////////////////////////////////////////////////////////////////////
// apb decode; one wait state so read data leaves a flop

wire        access  = psel & penable;
wire        commit  = access & pready;
wire        wrEn    = commit & pwrite;
wire [11:0] rel01   = paddr - `BGP_PAIR01_BASE;
wire [11:0] rel2    = paddr - `BGP_PAIR2_BASE;
wire        inPair01 = (paddr >= `BGP_PAIR01_BASE) &&
                       (paddr < `BGP_PAIR01_BASE + `BGP_PAIR_SPAN);
wire        inPair2  = (paddr >= `BGP_PAIR2_BASE) &&
                       (paddr < `BGP_PAIR2_BASE + `BGP_PAIR_SPAN);
wire        inPair  = inPair01 | inPair2;
wire [11:0] rel     = inPair01 ? rel01 : rel2;
wire        isId    = (paddr == `BGP_ID_OFS);
wire        isBank  = (paddr == `BGP_BANKEN_OFS);
wire        aligned = (paddr[1:0] == 2'b00);
wire        mapped  = aligned & (isId | isBank | inPair);

// pair01 carries banks 0/1, pair2 bank 2 in its low half
wire [47:0] lane  = inPair01 ? `BGP_PAIR01_LANES : `BGP_PAIR2_LANES;
wire [47:0] wd48  = inPair01 ? {16'h0000, pwdata} :
                               {pwdata[15:0], 32'h0000_0000};
wire [47:0] wbits = wd48 & lane;
wire [47:0] outOk = ~dirIn & POP_MASK;

wire wDir    = wrEn & inPair & (rel == `BGP_DIR_OFS);
wire wOut    = wrEn & inPair & (rel == `BGP_OUT_OFS);
wire wSet    = wrEn & inPair & (rel == `BGP_SET_OFS);
wire wClr    = wrEn & inPair & (rel == `BGP_CLR_OFS);
wire wSetRis = wrEn & inPair & (rel == `BGP_SETRIS_OFS);
wire wClrRis = wrEn & inPair & (rel == `BGP_CLRRIS_OFS);
wire wSetFal = wrEn & inPair & (rel == `BGP_SETFAL_OFS);
wire wClrFal = wrEn & inPair & (rel == `BGP_CLRFAL_OFS);
wire wStat   = wrEn & inPair & (rel == `BGP_STAT_OFS);
wire wBank   = wrEn & isBank;

////////////////////////////////////////////////////////////////////////////////
// answer sequencer: one wait state, then a one-cycle answer

localparam [1:0] AS_WAIT   = 2'b01;
localparam [1:0] AS_ANSWER = 2'b10;

reg  [1:0]  ansState;
reg  [1:0]  next_ansState;
wire        opening = access & (ansState == AS_WAIT);

always @*
begin
  case (ansState)
    AS_WAIT:
      next_ansState = access ? AS_ANSWER : AS_WAIT;
    AS_ANSWER:
      next_ansState = AS_WAIT;
    default:
      next_ansState = AS_WAIT;
  endcase
end

always @(posedge ref_clk)
begin
  if (srst)
    ansState <= AS_WAIT;
  else
    ansState <= next_ansState;
end

////////////////////////////////////////////////////////////////////////////////
// next register values

always @*
begin
  next_dirIn   = dirIn;
  next_outLvl  = outLvl;
  next_risEn   = risEn;
  next_falEn   = falEn;
  next_bankEn  = bankEn;
  next_intStat = intStat;
  if (wDir)
    next_dirIn = ((dirIn & ~lane) | wbits) & POP_MASK;
  if (wOut)
    next_outLvl = (outLvl & ~(lane & outOk)) | (wbits & outOk);
  if (wSet)
    next_outLvl = outLvl | (wbits & outOk);
  if (wClr)
    next_outLvl = outLvl & ~(wbits & outOk);
  if (wSetRis)
    next_risEn = risEn | (wbits & INT_MASK);
  if (wClrRis)
    next_risEn = risEn & ~wbits;
  if (wSetFal)
    next_falEn = falEn | (wbits & INT_MASK);
  if (wClrFal)
    next_falEn = falEn & ~wbits;
  if (wBank)
    next_bankEn = pwdata[2:0];
  // status: write one clears, a fresh edge in the same cycle wins
  if (wStat)
    next_intStat = intStat & ~wbits;
  next_intStat = next_intStat | ((riseEv & risEn) | (fallEv & falEn));
end

always @(posedge ref_clk)
begin
  if (srst)
  begin
    dirIn   <= `BGP_DIR_RST & POP_MASK;
    outLvl  <= `BGP_OUT_RST;
    risEn   <= 48'h0000_0000_0000;
    falEn   <= 48'h0000_0000_0000;
    intStat <= 48'h0000_0000_0000;
    bankEn  <= `BGP_BANKEN_RST;
  end
  else
  begin
    dirIn   <= next_dirIn;
    outLvl  <= next_outLvl & POP_MASK;
    risEn   <= next_risEn & INT_MASK;
    falEn   <= next_falEn & INT_MASK;
    intStat <= next_intStat & INT_MASK;
    bankEn  <= next_bankEn;
  end
end

////////////////////////////////////////////////////////////////////////////////
// pin drive

always @(posedge ref_clk)
begin
  if (srst)
  begin
    ioLineOut <= 48'h0000_0000_0000;
    ioLineOe  <= 48'h0000_0000_0000;
  end
  else
  begin
    ioLineOut <= next_outLvl & POP_MASK;
    ioLineOe  <= ~next_dirIn & POP_MASK;
  end
end

////////////////////////////////////////////////////////////////////////////////
// events toward cpus and the dma event controller

wire [47:0] rawEv = ((riseEv & risEn) | (fallEv & falEn)) & INT_MASK;
wire [47:0] enEv  = rawEv & {{16{bankEn[2]}}, {16{bankEn[1]}}, {16{bankEn[0]}}};

integer b;
reg [2:0] anyBank;

always @*
begin
  anyBank = 3'h0;
  for (b = 0; b < `BGP_BANKS; b = b + 1)
    anyBank[b] = |enEv[b*`BGP_BANK_W +: `BGP_BANK_W];
end

always @(posedge ref_clk)
begin
  if (srst)
  begin
    lineEvent <= 48'h0000_0000_0000;
    bankEvent <= 3'h0;
    dmaEvent  <= 3'h0;
  end
  else
  begin
    lineEvent <= enEv;
    bankEvent <= anyBank;
    dmaEvent  <= anyBank;
  end
end

////////////////////////////////////////////////////////////////////////////////
// read mux

reg [47:0] rsel;
reg [31:0] rword;

always @*
begin
  case (rel)
    `BGP_DIR_OFS:    rsel = dirIn;
    `BGP_OUT_OFS:    rsel = outLvl;
    `BGP_SET_OFS:    rsel = outLvl;
    `BGP_CLR_OFS:    rsel = outLvl;
    `BGP_IN_OFS:     rsel = inLvl & POP_MASK;
    `BGP_SETRIS_OFS: rsel = risEn;
    `BGP_CLRRIS_OFS: rsel = risEn;
    `BGP_SETFAL_OFS: rsel = falEn;
    `BGP_CLRFAL_OFS: rsel = falEn;
    `BGP_STAT_OFS:   rsel = intStat;
    default:         rsel = 48'h0000_0000_0000;
  endcase
  if (isId)
    rword = ID_VALUE;
  else if (isBank)
    rword = {29'h0, bankEn};
  else if (inPair01)
    rword = rsel[31:0];
  else if (inPair2)
    rword = {16'h0000, rsel[47:32]};
  else
    rword = 32'h0000_0000;
end

// either host reaches the block through the shared apb port
always @(posedge ref_clk)
begin
  if (srst)
  begin
    pready  <= 1'b0;
    prdata  <= 32'h0000_0000;
    pslverr <= 1'b0;
  end
  else
  begin
    pready  <= opening;
    pslverr <= opening & ~mapped;
    if (opening & ~pwrite & mapped)
      prdata <= rword;
    else if (commit)
      prdata <= 32'h0000_0000;
  end
end

endmodule
`default_nettype wire

/* File: tb/bgp_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module bgp_port_sva
#(
  parameter [47:0] POP_MASK = 48'h0,
  parameter [47:0] INT_MASK = 48'h0
)
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [47:0] ioLineOut,
  input wire logic [47:0] ioLineOe,
  input wire logic [47:0] lineEvent,
  input wire logic [2:0]  bankEvent,
  input wire logic [2:0]  dmaEvent
);
  wire [2:0] bankAny = {|lineEvent[47:32], |lineEvent[31:16], |lineEvent[15:0]};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  a_unpop_quiet: assert property (((ioLineOe | ioLineOut) & ~POP_MASK) == 48'h0)
    else $error("unpopulated line driven");
  a_event_mask: assert property ((lineEvent & ~INT_MASK) == 48'h0)
    else $error("event on line without capability");
  a_bank_event: assert property ((~bankEvent & bankAny) == 3'h0)
    else $error("line event without bank event");
  a_dma_same: assert property (dmaEvent == bankEvent)
    else $error("dma event differs from bank event");
  a_event_pulse: assert property (
    lineEvent != 48'h0 |=> (lineEvent & $past(lineEvent)) == 48'h0)
    else $error("line event longer than one cycle");
  a_oe_write: assert property ($changed(ioLineOe) |-> $past(pready && pwrite))
    else $error("drive enable changed without write");
  a_out_write: assert property ($changed(ioLineOut) |-> $past(pready && pwrite))
    else $error("output level changed without write");
  c_refused: cover property (pslverr);
  c_bank: cover property (bankEvent != 3'h0);
  c_drive: cover property ($rose(ioLineOe[0]));
endmodule
bind bgp_port bgp_port_sva #(.POP_MASK(POP_MASK), .INT_MASK(INT_MASK)) bgp_port_sva_inst (
  .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .ioLineOut(ioLineOut),
  .ioLineOe(ioLineOe), .lineEvent(lineEvent), .bankEvent(bankEvent), .dmaEvent(dmaEvent));
`default_nettype wire

/* File: tb/bgp_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bgp_pin_model
(
  input  wire logic [47:0] ioLineOut,
  input  wire logic [47:0] ioLineOe,
  input  wire logic [47:0] extLevel,
  output wire logic [47:0] ioLineIn
);
  // board parts drive every line the port leaves undriven
  assign ioLineIn = (ioLineOe & ioLineOut) | (~ioLineOe & extLevel);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bgp_map.vh"
module tb_top;
  localparam [47:0] POP = `BGP_POP_MASK;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [47:0] extLevel = 48'h0;
  logic [47:0] dirM = POP;
  logic [47:0] outM = 48'h0;
  logic [47:0] m, en;
  logic [31:0] seed = 32'h58;
  logic [31:0] rd;
  logic [31:0] expQ[$];
  logic        er;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [47:0] ioLineIn, ioLineOut, ioLineOe, lineEvent;
  wire  [2:0]  bankEvent, dmaEvent;
  int          fails = 0;
  int          n_checks = 0;
  int          i, k, p;
  always #12.5 ref_clk = ~ref_clk;
  bgp_port bgp_port_inst (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ioLineIn(ioLineIn), .ioLineOut(ioLineOut), .ioLineOe(ioLineOe),
    .lineEvent(lineEvent), .bankEvent(bankEvent), .dmaEvent(dmaEvent));
  bgp_pin_model bgp_pin_model_inst (.ioLineOut(ioLineOut), .ioLineOe(ioLineOe),
    .extLevel(extLevel), .ioLineIn(ioLineIn));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [47:0] lane(input int q, input logic [31:0] d);
    return q ? {d[15:0], 32'h0} : {16'h0, d};
  endfunction
  function automatic logic [31:0] half(input int q, input logic [47:0] v);
    return q ? {16'h0, v[47:32]} : v[31:0];
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chkPin(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkReg(input string nm, input logic [31:0] e, input logic [31:0] g);
    chkPin(nm, {16'h0, e}, {16'h0, g});
  endtask
  // request held until pready is sampled, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fails++;
      summarize;
    end
  endtask
  task automatic rdChk(input int q, input logic [11:0] o, input logic [31:0] e);
    apb(1'b0, (q ? `BGP_PAIR2_BASE : `BGP_PAIR01_BASE) + o, 32'h0);
    chkReg("read", e, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    for (p = 0; p < 2; p++)
      rdChk(p, `BGP_DIR_OFS, half(p, POP));
    chkPin("oe", 48'h0, ioLineOe);
    $display("reset test done");
    for (i = 0; i < 60; i++)
    begin
      seed = lfsr(seed);
      k = seed[1:0];
      p = seed[2];
      seed = lfsr(seed);
      m = lane(p, seed) & POP;
      en = POP & ~dirM;
      case (k)
        0: dirM = (dirM & ~lane(p, 32'hffff_ffff)) | m;
        1: outM = (outM & ~(lane(p, 32'hffff_ffff) & en)) | (m & en);
        2: outM = outM | (m & en);
        default: outM = outM & ~(m & en);
      endcase
      apb(1'b1, (p ? `BGP_PAIR2_BASE : `BGP_PAIR01_BASE) + 12'(4 * k), seed);
      @(negedge ref_clk);
      chkPin("oe", POP & ~dirM, ioLineOe);
      chkPin("out", outM & ~dirM, ioLineOut & ioLineOe);
      expQ.push_back(half(p, k ? outM : dirM));
      rdChk(p, 12'(4 * k), expQ.pop_front());
    end
    $display("data test done");
    @(posedge ref_clk);
    extLevel <= {lfsr(seed), seed[15:0]};
    repeat (10) @(posedge ref_clk);
    en = POP & ~dirM;
    for (p = 0; p < 2; p++)
      rdChk(p, `BGP_IN_OFS, half(p, ((en & outM) | (~en & extLevel)) & POP));
    apb(1'b0, 12'h004, 32'h0);
    chkReg("err", 32'h1, {31'h0, er});
    $display("input test done");
    extLevel <= 48'h0;
    dirM = POP;
    apb(1'b1, `BGP_PAIR01_BASE, 32'hffff_ffff);
    apb(1'b1, `BGP_PAIR2_BASE, 32'hffff_ffff);
    apb(1'b1, `BGP_BANKEN_OFS, 32'h7);
    apb(1'b1, `BGP_PAIR01_BASE + `BGP_SETRIS_OFS, 32'hffff_ffff);
    repeat (10) @(posedge ref_clk);
    extLevel <= 48'h201;
    k = 0;
    while (lineEvent[0] !== 1'b1 && k < 40)
    begin
      @(negedge ref_clk);
      k++;
    end
    if (lineEvent[0] !== 1'b1)
    begin
      fails++;
      summarize;
    end
    chkPin("event", 48'h1, lineEvent);
    chkPin("bank", 48'h1, {45'h0, dmaEvent});
    chkPin("bankev", 48'h1, {45'h0, bankEvent});
    rdChk(0, `BGP_STAT_OFS, 32'h1);
    apb(1'b1, `BGP_PAIR01_BASE + `BGP_STAT_OFS, 32'h1);
    rdChk(0, `BGP_STAT_OFS, 32'h0);
    apb(1'b1, `BGP_PAIR01_BASE + `BGP_CLRRIS_OFS, 32'hffff_ffff);
    apb(1'b1, `BGP_PAIR01_BASE + `BGP_SETFAL_OFS, 32'h1);
    apb(1'b1, `BGP_BANKEN_OFS, 32'h6);
    rdChk(0, `BGP_CLRRIS_OFS, 32'h0);
    rdChk(0, `BGP_SETFAL_OFS, 32'h1);
    extLevel <= 48'h0;
    m = 48'h0;
    for (k = 0; k < 20; k++)
    begin
      @(negedge ref_clk);
      m = m | lineEvent;
    end
    chkPin("masked", 48'h0, m);
    rdChk(0, `BGP_STAT_OFS, 32'h1);
    apb(1'b0, `BGP_ID_OFS, 32'h0);
    chkReg("id", `BGP_ID_VALUE, rd);
    $display("event test done");
    summarize;
  end
endmodule
`default_nettype wire
